// >>> channel_irq_map.vh
// Timing, preset address and field constants for the channel interrupt sequencer
`ifndef CHANNEL_IRQ_MAP_VH
`define CHANNEL_IRQ_MAP_VH
`define MC_LAST_PHASE 4'hB
`define T_A0 4'h0
`define T_A7 4'h7
`define T_A8 4'h8
`define PHASE_CLKS 8
`define INT_ADDR_FIRST 6'h22
`define INT_ADDR_SECOND 6'h23
`define RING_FULL 3'h6
`define MODE_LEN_BIT 11
`endif

// >>> machine_cycle_timer.v
// Twelve-phase machine cycle timer driven by a clock-enable divider
`timescale 1ns/100ps
`include "channel_irq_map.vh"
module machine_cycle_timer #(
  parameter PHASE_CLKS = `PHASE_CLKS
) (
  input wire clk,
  input wire rst_b,
  input wire start,
  output wire [3:0] phase,
  output wire running,
  output wire phaseStrobe,
  output wire cycleDone
);
  localparam [31:0] DIV_FULL = PHASE_CLKS - 1;
  localparam [7:0] DIV_LAST = DIV_FULL[7:0];
  reg [7:0] divCnt_r;
  reg [3:0] phase_r;
  reg running_r;
  reg strobe_r;
  reg done_r;

  assign phase = phase_r;
  assign running = running_r;
  assign phaseStrobe = strobe_r;
  assign cycleDone = done_r;

  // A start while a cycle runs is ignored; the sequencer never overlaps cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_r <= 8'h00;
      phase_r <= 4'h0;
      running_r <= 1'b0;
      strobe_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      strobe_r <= 1'b0;
      done_r <= 1'b0;
      if (start && !running_r) begin
        running_r <= 1'b1;
        phase_r <= 4'h0;
        divCnt_r <= 8'h00;
        strobe_r <= 1'b1;
      end else if (running_r) begin
        if (divCnt_r == DIV_LAST) begin
          divCnt_r <= 8'h00;
          if (phase_r == `MC_LAST_PHASE) begin
            running_r <= 1'b0;
            done_r <= 1'b1;
          end else begin
            phase_r <= phase_r + 4'h1;
            strobe_r <= 1'b1;
          end
        end else begin
          divCnt_r <= divCnt_r + 8'h01;
        end
      end
    end
  end
endmodule

// >>> channel_interrupt_sequencer.v
// Channel interrupt, length-mismatch, unusual-end and leave-interrupt sequencing
// What this block does
// - First step stores command counter at preset
// - First step forces read status, store counters
// - First preset address driven onto switches
// - Interrupt gate blocks address counter path
// - Starts at command request, fetch suppressed
// - Check gate drops, clears data-cycle request
// - Step two at A8, fetch skips a cycle
// - Second preset forced, command counter path blocked
// - Step two clears step one, normal after A0
// - Trap wait holds request reset until restart
// - Length check enable set by mode select
// - Too-long record on zero count, ring not 6
// - Too-short record on end with count nonzero
// - Incomplete word on end demand, ring not 6
// - Mismatches set the unusual-end trigger
// - Unusual end from selected interface, not during interrupt
// - Unusual ends interrupt unless mode disabled
// - Leave reads preset word, jumps in two steps
// - Leave cycles fetch, counter, command twice
// - Leave fetch loads at 7, decode at 0
// - Interrupt trigger holds until leave or reset
// - Check interrupts wait for data-selected drop
// - Leave counter cycle clears checks except attentions
`timescale 1ns/100ps
`include "channel_irq_map.vh"
module channel_interrupt_sequencer #(
  parameter PHASE_CLKS = `PHASE_CLKS,
  parameter [5:0] PRESET_FIRST = `INT_ADDR_FIRST,
  parameter [5:0] PRESET_SECOND = `INT_ADDR_SECOND
) (
  input wire clk,
  input wire rst_b,
  input wire chanReset,
  input wire cmdCycleReq,
  input wire ioCheckPending,
  input wire dataSelected,
  input wire trapWaitActive,
  input wire startChannel,
  input wire modeSelectStrobe,
  input wire [11:0] modeAddrCtr,
  input wire modeUnusualEnable,
  input wire wordCountZero,
  input wire copyDisconnect,
  input wire [2:0] asmRingPos,
  input wire endGate,
  input wire endDemand,
  input wire ifSelect,
  input wire unusualEndIf1,
  input wire unusualEndIf2,
  input wire cycleGrant,
  input wire leaveFetchStart,
  input wire leaveJumpCmd,
  output wire dataWordReq,
  output wire ctrlWordReq,
  output wire suppressFetch,
  output wire readStatus,
  output wire storeCounters,
  output wire inhibitOpDecode,
  output wire blockAddrCtrPath,
  output wire blockCmdCtrPath,
  output wire checkCondGate,
  output wire interruptOn,
  output wire intStep1,
  output wire intStep2,
  output wire leaveStep1,
  output wire leaveStep2,
  output wire [5:0] casAddr,
  output wire casDrive,
  output wire loadOpWordAddr,
  output wire cmdDecodeActive,
  output wire checkReset,
  output wire transferToAddr,
  output wire lengthCheckEn,
  output wire unusualEnd,
  output wire tooLong,
  output wire tooShort,
  output wire incompleteWord
);
  localparam [3:0] S_IDLE = 4'h0, S_I1_REQ = 4'h1, S_I1_CYC = 4'h2, S_I_GAP = 4'h3;
  localparam [3:0] S_I2_REQ = 4'h4, S_I2_CYC = 4'h5, S_L_B1 = 4'h6, S_L_C1 = 4'h7;
  localparam [3:0] S_L_M1 = 4'h8, S_L_REQ2 = 4'h9, S_L_B2 = 4'hA, S_L_C2 = 4'hB;
  localparam [3:0] S_L_M2 = 4'hC;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg intBdwReq_r, intTrig_r, trapHold_r, intStep1_r, intStep2_r;
  reg leaveStep1_r, leaveStep2_r, casDrive_r, loadPulse_r, decodeActive_r;
  reg checkReset_r, transfer_r, lenEn_r, ueEnable_r;
  reg unusualEnd_r, tooLong_r, tooShort_r, incomplete_r;
  reg [5:0] casAddr_r;

  wire [3:0] phase;
  wire running, phaseStrobe, cycleDone, timerStart, internalCycle, intCause, intBegin;
  wire ueSelected, longHit, shortHit, incompleteHit, clearChecks;

  function atPhase;
    input strobe;
    input [3:0] ph;
    input [3:0] want;
    begin
      atPhase = strobe && (ph == want);
    end
  endfunction

  // Gap, counter and command cycles run on the channel's own timing, no grant
  assign internalCycle = (state_r == S_I_GAP) || (state_r == S_L_C1) ||
    (state_r == S_L_M1) || (state_r == S_L_C2) || (state_r == S_L_M2);
  assign timerStart = (internalCycle && !running && !cycleDone) ||
    (cycleGrant && ((state_r == S_I1_REQ) || (state_r == S_I2_REQ) ||
    (state_r == S_L_REQ2))) || (leaveFetchStart && (state_r == S_IDLE));

  machine_cycle_timer #(
    .PHASE_CLKS(PHASE_CLKS)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(timerStart),
    .phase(phase),
    .running(running),
    .phaseStrobe(phaseStrobe),
    .cycleDone(cycleDone)
  );

  // Check-type causes wait until the adapter is no longer data selected
  assign intCause = (ioCheckPending && !dataSelected) || (unusualEnd_r && ueEnable_r);
  assign checkCondGate = !intTrig_r;
  assign intBegin = intBdwReq_r && (state_r == S_IDLE);
  assign ueSelected = ifSelect ? unusualEndIf2 : unusualEndIf1;
  assign longHit = lenEn_r && wordCountZero && copyDisconnect && (asmRingPos != `RING_FULL);
  assign shortHit = lenEn_r && endGate && !wordCountZero;
  assign incompleteHit = lenEn_r && endDemand && copyDisconnect &&
    (asmRingPos != `RING_FULL);
  assign clearChecks = checkReset_r || chanReset;

  assign dataWordReq = (state_r == S_I1_REQ);
  assign ctrlWordReq = (state_r == S_I2_REQ) || (state_r == S_L_REQ2);
  assign suppressFetch = intBdwReq_r || (state_r == S_I1_REQ);
  assign readStatus = intStep1_r;
  assign storeCounters = (state_r == S_I1_CYC) && running;
  assign inhibitOpDecode = intStep1_r || leaveStep2_r;
  assign blockAddrCtrPath = intStep1_r || leaveStep1_r;
  assign blockCmdCtrPath = intStep2_r || leaveStep1_r;
  assign interruptOn = intTrig_r;
  assign intStep1 = intStep1_r;
  assign intStep2 = intStep2_r;
  assign leaveStep1 = leaveStep1_r;
  assign leaveStep2 = leaveStep2_r;
  assign casAddr = casAddr_r;
  assign casDrive = casDrive_r;
  assign loadOpWordAddr = loadPulse_r;
  assign cmdDecodeActive = decodeActive_r;
  assign checkReset = checkReset_r;
  assign transferToAddr = transfer_r;
  assign lengthCheckEn = lenEn_r;
  assign unusualEnd = unusualEnd_r;
  assign tooLong = tooLong_r;
  assign tooShort = tooShort_r;
  assign incompleteWord = incomplete_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (intBegin) begin
          state_nxt = S_I1_REQ;
        end else if (leaveFetchStart) begin
          state_nxt = S_L_B1;
        end
      end
      // State codes run in sequence order, so every step forward except S_IDLE to S_L_B1 is one code up
      S_I1_REQ, S_I2_REQ, S_L_REQ2: begin
        if (cycleGrant) begin
          state_nxt = state_r + 4'h1;
        end
      end
      S_I1_CYC, S_I_GAP, S_L_B1, S_L_C1, S_L_M1, S_L_B2, S_L_C2: begin
        if (cycleDone) begin
          state_nxt = state_r + 4'h1;
        end
      end
      S_I2_CYC, S_L_M2: begin
        if (cycleDone) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Sequencer state and interrupt triggers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      intBdwReq_r <= 1'b0;
      intTrig_r <= 1'b0;
      trapHold_r <= 1'b0;
      intStep1_r <= 1'b0;
      intStep2_r <= 1'b0;
      leaveStep1_r <= 1'b0;
      leaveStep2_r <= 1'b0;
      casAddr_r <= 6'h00;
      casDrive_r <= 1'b0;
      loadPulse_r <= 1'b0;
      decodeActive_r <= 1'b0;
      checkReset_r <= 1'b0;
      transfer_r <= 1'b0;
    end else if (chanReset) begin
      state_r <= S_IDLE;
      intBdwReq_r <= 1'b0;
      intTrig_r <= 1'b0;
      trapHold_r <= 1'b0;
      intStep1_r <= 1'b0;
      intStep2_r <= 1'b0;
      leaveStep1_r <= 1'b0;
      leaveStep2_r <= 1'b0;
      casAddr_r <= 6'h00;
      casDrive_r <= 1'b0;
      loadPulse_r <= 1'b0;
      decodeActive_r <= 1'b0;
      checkReset_r <= 1'b0;
      transfer_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      loadPulse_r <= 1'b0;
      checkReset_r <= 1'b0;
      transfer_r <= 1'b0;
      // Trap wait keeps pending interrupts back until the computer restarts the channel
      if (trapWaitActive) begin
        trapHold_r <= 1'b1;
      end else if (startChannel) begin
        trapHold_r <= 1'b0;
      end
      if (trapHold_r || trapWaitActive || intTrig_r) begin
        intBdwReq_r <= 1'b0;
      end else if (cmdCycleReq && intCause && state_r == S_IDLE) begin
        intBdwReq_r <= 1'b1;
      end
      if (intBegin) begin
        intTrig_r <= 1'b1;
        intStep1_r <= 1'b1;
        casAddr_r <= PRESET_FIRST;
        casDrive_r <= 1'b1;
      end else if ((state_r == S_L_M1 && atPhase(phaseStrobe, phase, `T_A0)) ||
          leaveJumpCmd) begin
        intTrig_r <= 1'b0;
      end
      if (state_r == S_I1_CYC && atPhase(phaseStrobe, phase, `T_A8)) begin
        intStep2_r <= 1'b1;
      end
      if (state_r == S_I_GAP && cycleDone) begin
        casAddr_r <= PRESET_SECOND;
      end
      if (state_r == S_I2_REQ && cycleGrant) begin
        intStep1_r <= 1'b0;
      end
      if (state_r == S_I2_CYC && atPhase(phaseStrobe, phase, `T_A0)) begin
        intStep2_r <= 1'b0;
        casDrive_r <= 1'b0;
      end
      if ((state_r == S_L_B1 || state_r == S_L_B2) && atPhase(phaseStrobe, phase, `T_A7)) begin
        loadPulse_r <= 1'b1;
      end
      if (state_r == S_L_C1 && atPhase(phaseStrobe, phase, `T_A0)) begin
        decodeActive_r <= 1'b1;
        checkReset_r <= 1'b1;
      end
      if (leaveJumpCmd) begin
        checkReset_r <= 1'b1;
      end
      if (state_r == S_L_M1 && atPhase(phaseStrobe, phase, `T_A0)) begin
        leaveStep1_r <= 1'b1;
        casAddr_r <= PRESET_FIRST;
        casDrive_r <= 1'b1;
      end
      if (state_r == S_L_B2 && atPhase(phaseStrobe, phase, `T_A7)) begin
        leaveStep2_r <= 1'b1;
      end
      if (state_r == S_L_B2 && cycleDone) begin
        casDrive_r <= 1'b0;
      end
      if (state_r == S_L_M2 && cycleDone) begin
        leaveStep1_r <= 1'b0;
        leaveStep2_r <= 1'b0;
        decodeActive_r <= 1'b0;
        transfer_r <= 1'b1;
      end
    end
  end

  // Mode bits and end-condition triggers; a new end event wins over the clearing reset, chanReset wins over a mode select
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lenEn_r <= 1'b0;
      ueEnable_r <= 1'b1;
      unusualEnd_r <= 1'b0;
      tooLong_r <= 1'b0;
      tooShort_r <= 1'b0;
      incomplete_r <= 1'b0;
    end else begin
      if (chanReset) begin
        lenEn_r <= 1'b0;
        ueEnable_r <= 1'b1;
      end else if (modeSelectStrobe) begin
        lenEn_r <= modeAddrCtr[`MODE_LEN_BIT];
        ueEnable_r <= modeUnusualEnable;
      end
      if (longHit || shortHit || incompleteHit || (ueSelected && !intTrig_r)) begin
        unusualEnd_r <= 1'b1;
      end else if (clearChecks) begin
        unusualEnd_r <= 1'b0;
      end
      if (longHit) begin
        tooLong_r <= 1'b1;
      end else if (clearChecks) begin
        tooLong_r <= 1'b0;
      end
      if (shortHit) begin
        tooShort_r <= 1'b1;
      end else if (clearChecks) begin
        tooShort_r <= 1'b0;
      end
      if (incompleteHit) begin
        incomplete_r <= 1'b1;
      end else if (clearChecks) begin
        incomplete_r <= 1'b0;
      end
    end
  end
endmodule

// >>> core_mux_model.sv
// Behavioural multiplexor and core storage answering B-cycle requests
`timescale 1ns/100ps
module core_mux_model (
  input wire clk,
  input wire rst_b,
  input wire dataWordReq,
  input wire ctrlWordReq,
  input wire [3:0] lat,
  output reg cycleGrant
);
  reg [3:0] waitCnt_r;
  // One-cycle grant, none in the next cycle; a request still held is granted again lat+2 cycles after the first grant
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 4'h0;
      cycleGrant <= 1'b0;
    end else begin
      cycleGrant <= 1'b0;
      if ((dataWordReq || ctrlWordReq) && !cycleGrant) begin
        if (waitCnt_r >= lat) begin
          cycleGrant <= 1'b1;
          waitCnt_r <= 4'h0;
        end else begin
          waitCnt_r <= waitCnt_r + 4'h1;
        end
      end else begin
        waitCnt_r <= 4'h0;
      end
    end
  end
endmodule

// >>> channel_interrupt_sequencer_sva.sv
// Port-level checker for the channel interrupt sequencer
`timescale 1ns/100ps
module ciq_checker (
  input clk,
  input rst_b,
  input chanReset,
  input leaveJumpCmd,
  input modeSelectStrobe,
  input [11:0] modeAddrCtr,
  input wordCountZero,
  input copyDisconnect,
  input [2:0] asmRingPos,
  input endGate,
  input endDemand,
  input dataWordReq,
  input ctrlWordReq,
  input readStatus,
  input inhibitOpDecode,
  input blockAddrCtrPath,
  input blockCmdCtrPath,
  input checkCondGate,
  input interruptOn,
  input intStep1,
  input intStep2,
  input leaveStep1,
  input [5:0] casAddr,
  input casDrive,
  input lengthCheckEn,
  input unusualEnd,
  input tooLong,
  input tooShort,
  input incompleteWord
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_cas_first: assert property (dataWordReq |-> casDrive && casAddr == 6'h22)
    else $error("first preset address not driven");
  a_step1_status: assert property ($rose(intStep1) |-> readStatus && !checkCondGate)
    else $error("step one without read status or with check gate");
  a_addr_block: assert property (intStep1 |-> blockAddrCtrPath && inhibitOpDecode)
    else $error("address path or decode not blocked");
  a_gate_inv: assert property (checkCondGate != interruptOn)
    else $error("check gate not inverse of interrupt trigger");
  a_fetch_gap: assert property ($rose(intStep2) |-> !ctrlWordReq [*8])
    else $error("fetch requested in the next machine cycle");
  a_cas_second: assert property (ctrlWordReq && intStep2 |->
    casAddr == 6'h23 && blockCmdCtrPath)
    else $error("second preset address or command path block missing");
  a_step1_clear: assert property ($fell(ctrlWordReq) && intStep2 |-> !intStep1)
    else $error("step one not cleared at fetch grant");
  a_len_en: assert property ($past(modeSelectStrobe) && !$past(chanReset) |->
    lengthCheckEn == $past(modeAddrCtr[11]))
    else $error("length check enable not loaded");
  a_too_long: assert property (lengthCheckEn && wordCountZero && copyDisconnect &&
    asmRingPos != 3'h6 |=> tooLong && unusualEnd)
    else $error("too long record not flagged");
  a_too_short: assert property (lengthCheckEn && endGate && !wordCountZero |=>
    tooShort && unusualEnd)
    else $error("too short record not flagged");
  a_part_word: assert property (lengthCheckEn && endDemand && copyDisconnect &&
    asmRingPos != 3'h6 |=> incompleteWord && unusualEnd)
    else $error("incomplete word not flagged");
  a_int_hold: assert property ($fell(interruptOn) |->
    leaveStep1 || $past(leaveJumpCmd) || $past(chanReset))
    else $error("interrupt trigger dropped without leave or reset");
endmodule
bind channel_interrupt_sequencer ciq_checker u_chk (.clk, .rst_b, .chanReset,
  .leaveJumpCmd, .modeSelectStrobe, .modeAddrCtr, .wordCountZero, .copyDisconnect,
  .asmRingPos, .endGate, .endDemand, .dataWordReq, .ctrlWordReq, .readStatus,
  .inhibitOpDecode, .blockAddrCtrPath, .blockCmdCtrPath, .checkCondGate, .interruptOn,
  .intStep1, .intStep2, .leaveStep1, .casAddr, .casDrive, .lengthCheckEn, .unusualEnd,
  .tooLong, .tooShort, .incompleteWord);

// >>> channel_interrupt_sequencer_tb.sv
// Self-checking bench for the channel interrupt sequencer
`timescale 1ns/100ps
module channel_interrupt_sequencer_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg chanReset = 1'b0, cmdCycleReq = 1'b0, trapWaitActive = 1'b0, startChannel = 1'b0;
  reg modeSelectStrobe = 1'b0, modeUnusualEnable = 1'b1, wordCountZero = 1'b0;
  reg copyDisconnect = 1'b0, endGate = 1'b0, endDemand = 1'b0, leaveFetchStart = 1'b0;
  reg leaveJumpCmd = 1'b0;
  reg ioCheckPending = 1'b0, dataSelected = 1'b0, ifSelect = 1'b0;
  reg unusualEndIf1 = 1'b0, unusualEndIf2 = 1'b0;
  reg [11:0] modeAddrCtr = 12'h000;
  reg [2:0] asmRingPos = 3'h0;
  reg [3:0] lat = 4'h2;
  wire dataWordReq, ctrlWordReq, readStatus, inhibitOpDecode, blockAddrCtrPath;
  wire blockCmdCtrPath, checkCondGate, interruptOn, intStep1, intStep2, leaveStep1;
  wire casDrive, transferToAddr, lengthCheckEn, unusualEnd, tooLong, tooShort;
  wire incompleteWord, cycleGrant, suppressFetch, cmdDecodeActive;
  wire [5:0] casAddr;
  integer bad_count = 0;
  integer checked = 0;
  always #5 clk = ~clk;
  channel_interrupt_sequencer #(.PHASE_CLKS(1)) uut (.clk, .rst_b, .chanReset,
    .cmdCycleReq, .ioCheckPending, .dataSelected, .trapWaitActive,
    .startChannel, .modeSelectStrobe, .modeAddrCtr, .modeUnusualEnable, .wordCountZero,
    .copyDisconnect, .asmRingPos, .endGate, .endDemand, .ifSelect,
    .unusualEndIf1, .unusualEndIf2, .cycleGrant, .leaveFetchStart,
    .leaveJumpCmd, .dataWordReq, .ctrlWordReq, .suppressFetch, .readStatus,
    .storeCounters(), .inhibitOpDecode, .blockAddrCtrPath, .blockCmdCtrPath,
    .checkCondGate, .interruptOn, .intStep1, .intStep2, .leaveStep1, .leaveStep2(),
    .casAddr, .casDrive, .loadOpWordAddr(), .cmdDecodeActive, .checkReset(),
    .transferToAddr, .lengthCheckEn, .unusualEnd, .tooLong, .tooShort, .incompleteWord);
  core_mux_model mux (.clk, .rst_b, .dataWordReq, .ctrlWordReq, .lat, .cycleGrant);
  task results;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk1(input string n, input logic e, input logic g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task chk6(input string n, input [5:0] e, input [5:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  function logic sel(input integer w);
    case (w)
      0: sel = dataWordReq;
      1: sel = ctrlWordReq;
      2: sel = casDrive;
      3: sel = leaveStep1;
      default: sel = transferToAddr;
    endcase
  endfunction
  // Bounded so a missing handshake shows as a mismatch, not a hang
  task waitFor(input integer w, input logic v);
    integer k;
    begin
      k = 0;
      while (sel(w) !== v && k < 400) begin
        step;
        k = k + 1;
      end
      chk1("wait", v, sel(w));
    end
  endtask
  task mode(input [11:0] a, input logic ue);
    begin
      @(posedge clk);
      modeAddrCtr <= a;
      modeUnusualEnable <= ue;
      modeSelectStrobe <= 1'b1;
      @(posedge clk);
      modeSelectStrobe <= 1'b0;
      step;
    end
  endtask
  task runInt;
    begin
      @(posedge clk);
      cmdCycleReq <= 1'b1;
      @(posedge clk);
      cmdCycleReq <= 1'b0;
      waitFor(0, 1'b1);
      chk6("casAddr", 6'h22, casAddr);
      chk1("readStatus", 1'b1, readStatus);
      chk1("blockAddr", 1'b1, blockAddrCtrPath);
      chk1("inhibitOp", 1'b1, inhibitOpDecode);
      chk1("suppressFetch", 1'b1, suppressFetch);
      chk1("checkGate", 1'b0, checkCondGate);
      waitFor(1, 1'b1);
      chk1("intStep2", 1'b1, intStep2);
      chk6("casAddr", 6'h23, casAddr);
      chk1("blockCmd", 1'b1, blockCmdCtrPath);
      waitFor(2, 1'b0);
      chk1("intStep1", 1'b0, intStep1);
      repeat (20) step;
      chk1("interruptOn", 1'b1, interruptOn);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    step;
    chk1("checkGate", 1'b1, checkCondGate);
    chk1("interruptOn", 1'b0, interruptOn);
    mode(12'h800, 1'b1);
    chk1("lengthEn", 1'b1, lengthCheckEn);
    @(posedge clk);
    endGate <= 1'b1;
    @(posedge clk);
    endGate <= 1'b0;
    step;
    chk1("tooShort", 1'b1, tooShort);
    chk1("unusualEnd", 1'b1, unusualEnd);
    chk1("tooLong", 1'b0, tooLong);
    @(posedge clk);
    trapWaitActive <= 1'b1;
    cmdCycleReq <= 1'b1;
    repeat (6) step;
    chk1("dataWordReq", 1'b0, dataWordReq);
    @(posedge clk);
    cmdCycleReq <= 1'b0;
    trapWaitActive <= 1'b0;
    startChannel <= 1'b1;
    @(posedge clk);
    startChannel <= 1'b0;
    runInt;
    @(posedge clk);
    leaveFetchStart <= 1'b1;
    @(posedge clk);
    leaveFetchStart <= 1'b0;
    waitFor(3, 1'b1);
    chk1("interruptOn", 1'b0, interruptOn);
    chk6("casAddr", 6'h22, casAddr);
    chk1("decodeActive", 1'b1, cmdDecodeActive);
    waitFor(4, 1'b1);
    chk1("leaveStep1", 1'b0, leaveStep1);
    @(posedge clk);
    chanReset <= 1'b1;
    @(posedge clk);
    chanReset <= 1'b0;
    step;
    chk1("lengthEn", 1'b0, lengthCheckEn);
    chk1("unusualEnd", 1'b0, unusualEnd);
    mode(12'h800, 1'b1);
    @(posedge clk);
    lat <= 4'h6;
    copyDisconnect <= 1'b1;
    wordCountZero <= 1'b1;
    asmRingPos <= 3'h3;
    endDemand <= 1'b1;
    @(posedge clk);
    wordCountZero <= 1'b0;
    endDemand <= 1'b0;
    step;
    chk1("tooLong", 1'b1, tooLong);
    chk1("incomplete", 1'b1, incompleteWord);
    chk1("unusualEnd", 1'b1, unusualEnd);
    mode(12'h000, 1'b0);
    chk1("lengthEn", 1'b0, lengthCheckEn);
    @(posedge clk);
    cmdCycleReq <= 1'b1;
    @(posedge clk);
    cmdCycleReq <= 1'b0;
    repeat (6) step;
    chk1("interruptOn", 1'b0, interruptOn);
    mode(12'h000, 1'b1);
    runInt;
    @(posedge clk);
    leaveJumpCmd <= 1'b1;
    @(posedge clk);
    leaveJumpCmd <= 1'b0;
    step;
    chk1("interruptOn", 1'b0, interruptOn);
    @(posedge clk);
    ifSelect <= 1'b1;
    unusualEndIf1 <= 1'b1;
    @(posedge clk);
    unusualEndIf1 <= 1'b0;
    step;
    chk1("unusualEnd", 1'b0, unusualEnd);
    @(posedge clk);
    unusualEndIf2 <= 1'b1;
    @(posedge clk);
    unusualEndIf2 <= 1'b0;
    step;
    chk1("unusualEnd", 1'b1, unusualEnd);
    @(posedge clk);
    chanReset <= 1'b1;
    ioCheckPending <= 1'b1;
    dataSelected <= 1'b1;
    @(posedge clk);
    chanReset <= 1'b0;
    cmdCycleReq <= 1'b1;
    @(posedge clk);
    cmdCycleReq <= 1'b0;
    repeat (6) step;
    chk1("interruptOn", 1'b0, interruptOn);
    @(posedge clk);
    dataSelected <= 1'b0;
    runInt;
    @(posedge clk);
    unusualEndIf2 <= 1'b1;
    @(posedge clk);
    unusualEndIf2 <= 1'b0;
    step;
    chk1("unusualEnd", 1'b0, unusualEnd);
    results;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    results;
  end
endmodule
